/* File: wkt_pkg.sv */
// wake timer package: register map, field layout, timing counts
// assumes a 25 MHz system clock and a 32.768 kHz tick from one of two pins
package wkt_pkg;
  // register byte offsets on the 32-bit bus
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_MANT_HIGH = 8'h04;
  localparam logic [7:0] ADDR_MANT_LOW = 8'h08;
  localparam logic [7:0] ADDR_EXP_STATE = 8'h0c;
  localparam logic [7:0] ADDR_DUTY_WIN = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h18;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h1c;
  localparam logic [7:0] ADDR_CONTROL = 8'h20;
  localparam logic [7:0] ADDR_STATE = 8'h24;
  // config field positions, and the post-expiry state bit of the exponent register
  localparam int CFG_TIMER_EN = 0;
  localparam int CFG_BATT_EN = 1;
  localparam int CFG_DUTY_LO = 2;
  localparam int CFG_CAL_EN = 4;
  localparam int CFG_RECAL_LO = 5;
  localparam int EXP_SLEEP_BIT = 5;
  // control register fields
  localparam int CTL_CLK_SEL = 0;
  localparam int CTL_POWER_UP = 1;
  localparam int CTL_SHUTDOWN = 2;
  // status bits
  localparam int ST_EXPIRED = 0;
  localparam int ST_CAL_DONE = 1;
  localparam int ST_WINDOW_END = 2;
  localparam int NUM_ST = 3;
  // reset values
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_MANT_HIGH = 8'h00;
  localparam logic [7:0] RST_MANT_LOW = 8'h01;
  localparam logic [7:0] RST_EXP_STATE = 8'h00;
  localparam logic [7:0] RST_DUTY_WIN = 8'h00;
  // one period unit is 4 ticks of 32 kHz, shifted by the exponent
  localparam int TICK_PER_UNIT = 4;
  localparam int XTAL_HZ = 30000000;
  localparam int SLOW_HZ = 32768;
  // calibration: count reference edges over a window of slow ticks
  localparam int CAL_TICKS = 16;
  localparam int XTAL_START_NS = 250000;
  localparam int CLK_NS = 40;
  localparam int XTAL_START_CYC = (XTAL_START_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [31:0] CAL_EXPECT = 32'((64'(XTAL_HZ) * CAL_TICKS) / SLOW_HZ);
  // duty action codes
  localparam logic [1:0] DUTY_OFF = 2'h0;
  localparam logic [1:0] DUTY_RX = 2'h1;
  localparam logic [1:0] DUTY_TX = 2'h2;
  typedef enum logic [3:0] {
    CAL_IDLE = 4'b0001,
    CAL_XSTART = 4'b0010,
    CAL_MEASURE = 4'b0100,
    CAL_ADJUST = 4'b1000
  } wkt_cal_state_t;
  typedef struct packed {
    logic wake_rx;
    logic wake_tx;
    logic batt_meas;
    logic to_sleep;
    logic to_ready;
  } wkt_action_t;
endpackage : wkt_pkg

/* File: wkt_timer.sv */
// wake timer: 32 kHz period counter, rc recalibration, axi4-lite registers
// assumes slow clock pins are asynchronous to clk_i; ref pin toggles at xtal rate
// Notes on behaviour
// R01: count from rc oscillator or 32 kHz crystal
// R02: runs period when enable set, even asleep
// R03: expiry drives active-low interrupt when enabled
// R04: host confirms cause by reading status
// R05: period equals mantissa times four times two^exp
// R06: calibrate rc at power-up and shutdown exit; with the crystal selected the rc trim is left unchanged
// R07: periodic recalibration only with enable, 3-bit interval
// R08: calibration starts crystal, measures, adjusts rc; with the crystal selected it does not measure and leaves rc_trim_o unchanged
// R09: battery measurement each interval when enabled
// R10: duty select: off, rx wake, tx wake
// R11: mantissa split across high and low bytes
// R12: five-bit exponent plus post-expiry state bit
// R13: duty window equals parameter times unit period
// R14: expiry sets sticky flag, reloads, read clears
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
module wkt_timer
  import wkt_pkg::*;
(
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // slow clock and crystal reference pins
  input wire logic rc_osc_i,
  input wire logic xtal32_i,
  input wire logic xtal_ref_i,
  // axi4-lite slave
  input wire logic [7:0] s_awaddr_i,
  input wire logic s_awvalid_i,
  output logic s_awready_o,
  input wire logic [31:0] s_wdata_i,
  input wire logic [3:0] s_wstrb_i,
  input wire logic s_wvalid_i,
  output logic s_wready_o,
  output logic [1:0] s_bresp_o,
  output logic s_bvalid_o,
  input wire logic s_bready_i,
  input wire logic [7:0] s_araddr_i,
  input wire logic s_arvalid_i,
  output logic s_arready_o,
  output logic [31:0] s_rdata_o,
  output logic [1:0] s_rresp_o,
  output logic s_rvalid_o,
  input wire logic s_rready_i,
  // chip side
  output logic interrupt_pin_n_o,
  output logic xtal_start_o,
  output logic [7:0] rc_trim_o,
  output wkt_action_t action_o,
  output logic duty_window_o
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] cfg_q, mant_hi_q, mant_lo_q, exp_q, duty_q;
  logic [NUM_ST-1:0] status_q, irq_en_q;
  logic clk_sel_q;
  logic aw_hold_q, w_hold_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic do_write, rd_fire;
  logic power_up_req, shutdown_exit_req;
  logic [NUM_ST-1:0] st_set;

  function automatic logic mapped(input logic [7:0] a);
    return a inside {ADDR_CONFIG, ADDR_MANT_HIGH, ADDR_MANT_LOW, ADDR_EXP_STATE, ADDR_DUTY_WIN,
                     ADDR_IRQ_STATUS, ADDR_IRQ_CLEAR, ADDR_IRQ_ENABLE, ADDR_CONTROL, ADDR_STATE};
  endfunction : mapped

  wire logic aw_have = aw_hold_q | (s_awvalid_i & s_awready_o);
  wire logic w_have = w_hold_q | (s_wvalid_i & s_wready_o);
  wire logic [7:0] wa = aw_hold_q ? aw_addr_q : s_awaddr_i;
  wire logic [31:0] wd = w_hold_q ? w_data_q : s_wdata_i;
  wire logic [3:0] ws = w_hold_q ? w_strb_q : s_wstrb_i;
  assign do_write = aw_have & w_have & ~s_bvalid_o;

  // write channels may arrive in either order; hold one until the other comes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
      s_awready_o <= 1'b0;
      s_wready_o <= 1'b0;
      s_bvalid_o <= 1'b0;
      s_bresp_o <= 2'h0;
    end else begin
      s_awready_o <= ~aw_hold_q & ~s_awready_o & ~s_bvalid_o & ~do_write;
      s_wready_o <= ~w_hold_q & ~s_wready_o & ~s_bvalid_o & ~do_write;
      if (s_awvalid_i & s_awready_o & ~do_write) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_awaddr_i;
      end
      if (s_wvalid_i & s_wready_o & ~do_write) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_wdata_i;
        w_strb_q <= s_wstrb_i;
      end
      if (do_write) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_bvalid_o <= 1'b1;
        s_bresp_o <= mapped(wa) ? 2'h0 : 2'h2;
      end else if (s_bready_i) begin
        s_bvalid_o <= 1'b0;
      end
    end
  end

  // direct write acceptance needs awready/wready high this cycle
  wire logic wr_ok = do_write & (aw_hold_q | s_awready_o) & (w_hold_q | s_wready_o);
  wire logic wr_lane0 = wr_ok & ws[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q <= RST_CONFIG;
      mant_hi_q <= RST_MANT_HIGH;
      mant_lo_q <= RST_MANT_LOW;
      exp_q <= RST_EXP_STATE;
      duty_q <= RST_DUTY_WIN;
      irq_en_q <= '0;
      clk_sel_q <= 1'b0;
    end else if (wr_lane0) begin
      unique case (wa)
        ADDR_CONFIG: cfg_q <= wd[7:0];
        ADDR_MANT_HIGH: mant_hi_q <= wd[7:0]; // [R11]
        ADDR_MANT_LOW: mant_lo_q <= wd[7:0]; // [R11]
        ADDR_EXP_STATE: exp_q <= {2'h0, wd[5:0]}; // [R12]
        ADDR_DUTY_WIN: duty_q <= wd[7:0];
        ADDR_IRQ_ENABLE: irq_en_q <= wd[NUM_ST-1:0];
        ADDR_CONTROL: clk_sel_q <= wd[CTL_CLK_SEL];
        default: ;
      endcase
    end
  end

  assign power_up_req = wr_lane0 & (wa == ADDR_CONTROL) & wd[CTL_POWER_UP];
  assign shutdown_exit_req = wr_lane0 & (wa == ADDR_CONTROL) & wd[CTL_SHUTDOWN];

  ////////////////////////////////////////////////////////////////////////////
  // read channel; a status read clears the flags it returned
  logic [31:0] rd_val;
  logic [NUM_ST-1:0] rd_clear;
  wkt_cal_state_t cal_q;
  logic running_q;
  assign rd_fire = s_arvalid_i & s_arready_o;

  always_comb begin
    unique case (s_araddr_i)
      ADDR_CONFIG: rd_val = {24'h0, cfg_q};
      ADDR_MANT_HIGH: rd_val = {24'h0, mant_hi_q};
      ADDR_MANT_LOW: rd_val = {24'h0, mant_lo_q};
      ADDR_EXP_STATE: rd_val = {24'h0, exp_q};
      ADDR_DUTY_WIN: rd_val = {24'h0, duty_q};
      ADDR_IRQ_STATUS: rd_val = {29'h0, status_q};
      ADDR_IRQ_ENABLE: rd_val = {29'h0, irq_en_q};
      ADDR_CONTROL: rd_val = {31'h0, clk_sel_q};
      ADDR_STATE: rd_val = {22'h0, rc_trim_o, cal_q == CAL_IDLE, running_q};
      default: rd_val = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_arready_o <= 1'b0;
      s_rvalid_o <= 1'b0;
      s_rdata_o <= 32'h0;
      s_rresp_o <= 2'h0;
    end else begin
      s_arready_o <= ~s_arready_o & ~s_rvalid_o;
      if (rd_fire) begin
        s_rvalid_o <= 1'b1;
        s_rdata_o <= rd_val;
        s_rresp_o <= (mapped(s_araddr_i) && s_araddr_i != ADDR_IRQ_CLEAR) ? 2'h0 : 2'h2;
      end else if (s_rready_i) begin
        s_rvalid_o <= 1'b0;
      end
    end
  end

  // host confirms the cause here; set beats clear in the same cycle
  always_comb begin
    rd_clear = '0;
    if (rd_fire && s_araddr_i == ADDR_IRQ_STATUS) rd_clear = status_q; // [R04] [R14]
    if (wr_lane0 && wa == ADDR_IRQ_CLEAR) rd_clear = rd_clear | wd[NUM_ST-1:0];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) status_q <= '0;
    else status_q <= (status_q & ~rd_clear) | st_set; // [R14]
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) interrupt_pin_n_o <= 1'b1;
    else interrupt_pin_n_o <= ~|(status_q & irq_en_q); // [R03]
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three stages, change counted when stages 2 and 3 agree
  logic [2:0] rc_s_q, xt_s_q, ref_s_q;
  logic slow_lvl_q, ref_lvl_q, slow_tick, ref_tick;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rc_s_q <= 3'h0;
      xt_s_q <= 3'h0;
      ref_s_q <= 3'h0;
      slow_lvl_q <= 1'b0;
      ref_lvl_q <= 1'b0;
    end else begin
      rc_s_q <= {rc_s_q[1:0], rc_osc_i};
      xt_s_q <= {xt_s_q[1:0], xtal32_i};
      ref_s_q <= {ref_s_q[1:0], xtal_ref_i};
      if (clk_sel_q ? (xt_s_q[1] == xt_s_q[2]) : (rc_s_q[1] == rc_s_q[2]))
        slow_lvl_q <= clk_sel_q ? xt_s_q[2] : rc_s_q[2]; // [R01]
      if (ref_s_q[1] == ref_s_q[2]) ref_lvl_q <= ref_s_q[2];
    end
  end
  // rising edge of the chosen slow clock; the ref is above clk_i so it
  // is really a divided crystal monitor, limited to clk_i/4 by sampling
  assign slow_tick = (clk_sel_q ? (xt_s_q[1] & xt_s_q[2]) : (rc_s_q[1] & rc_s_q[2])) & ~slow_lvl_q;
  assign ref_tick = ref_s_q[1] & ref_s_q[2] & ~ref_lvl_q;

  ////////////////////////////////////////////////////////////////////////////
  // period counter: mantissa units of 4 * 2^exp slow ticks
  logic [36:0] unit_cnt_q;
  logic [15:0] mant_cnt_q, win_cnt_q;
  logic win_q;
  wire logic [15:0] mantissa = {mant_hi_q, mant_lo_q}; // [R11]
  wire logic [36:0] unit_len = 37'(TICK_PER_UNIT) << exp_q[4:0]; // [R05] [R12]
  wire logic unit_done = slow_tick && (unit_cnt_q + 37'h1 >= unit_len);
  wire logic expire = running_q && unit_done && (mant_cnt_q + 16'h1 >= mantissa);
  wire logic [1:0] duty_sel = cfg_q[CFG_DUTY_LO +: 2];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      running_q <= 1'b0;
      unit_cnt_q <= '0;
      mant_cnt_q <= 16'h0;
    end else if (!cfg_q[CFG_TIMER_EN]) begin
      running_q <= 1'b0;
      unit_cnt_q <= '0;
      mant_cnt_q <= 16'h0;
    end else begin
      running_q <= 1'b1; // [R02]
      if (running_q && slow_tick) begin
        unit_cnt_q <= unit_done ? '0 : unit_cnt_q + 37'h1;
        if (expire) mant_cnt_q <= 16'h0; // [R14]
        else if (unit_done) mant_cnt_q <= mant_cnt_q + 16'h1;
      end
    end
  end

  // active window after a duty wake: duty_q units long; a stopped timer
  // closes it, since no unit would ever end it
  always_ff @(posedge clk_i) begin
    if (rst_i || !cfg_q[CFG_TIMER_EN]) begin
      win_q <= 1'b0;
      win_cnt_q <= 16'h0;
    end else if (expire && duty_sel != DUTY_OFF && duty_q != 8'h00) begin
      win_q <= 1'b1;
      win_cnt_q <= 16'h0;
    end else if (win_q && unit_done) begin
      if (win_cnt_q + 16'h1 >= {8'h00, duty_q}) win_q <= 1'b0; // [R13]
      win_cnt_q <= win_cnt_q + 16'h1;
    end
  end
  assign duty_window_o = win_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) action_o <= '0;
    else begin
      action_o.wake_rx <= expire && duty_sel == DUTY_RX; // [R10]
      action_o.wake_tx <= expire && duty_sel == DUTY_TX; // [R10]
      action_o.batt_meas <= expire && cfg_q[CFG_BATT_EN]; // [R09]
      action_o.to_sleep <= expire && exp_q[EXP_SLEEP_BIT]; // [R12]
      action_o.to_ready <= expire && !exp_q[EXP_SLEEP_BIT]; // [R12]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // rc calibration
  logic [31:0] cal_cnt_q, recal_cnt_q;
  logic [15:0] cal_tick_q;
  wire logic [31:0] recal_len = 32'(SLOW_HZ) << cfg_q[CFG_RECAL_LO +: 3]; // [R07]
  wire logic recal_due = cfg_q[CFG_CAL_EN] && slow_tick && (recal_cnt_q + 32'h1 >= recal_len);
  wire logic cal_start = power_up_req | shutdown_exit_req | recal_due; // [R06] [R07]

  always_ff @(posedge clk_i) begin
    if (rst_i || !cfg_q[CFG_CAL_EN] || recal_due) recal_cnt_q <= 32'h0;
    else if (slow_tick) recal_cnt_q <= recal_cnt_q + 32'h1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cal_q <= CAL_IDLE;
      cal_cnt_q <= 32'h0;
      cal_tick_q <= 16'h0;
      rc_trim_o <= 8'h80;
      xtal_start_o <= 1'b0;
    end else begin
      unique case (cal_q)
        CAL_IDLE: if (cal_start) begin
          cal_q <= CAL_XSTART;
          xtal_start_o <= 1'b1; // [R08]
          cal_cnt_q <= 32'h0;
        end
        CAL_XSTART: begin
          cal_cnt_q <= cal_cnt_q + 32'h1;
          if (cal_cnt_q + 32'h1 >= 32'(XTAL_START_CYC)) begin
            cal_q <= CAL_MEASURE;
            cal_cnt_q <= 32'h0;
            cal_tick_q <= 16'h0;
          end
        end
        CAL_MEASURE: begin
          if (ref_tick) cal_cnt_q <= cal_cnt_q + 32'h1; // [R08]
          if (slow_tick && !clk_sel_q) begin
            cal_tick_q <= cal_tick_q + 16'h1;
            if (cal_tick_q + 16'h1 >= 16'(CAL_TICKS)) cal_q <= CAL_ADJUST;
          end
          if (clk_sel_q) cal_q <= CAL_ADJUST;
        end
        CAL_ADJUST: begin
          // more ref edges than expected means rc too slow: raise trim
          if (!clk_sel_q && cal_cnt_q > CAL_EXPECT && rc_trim_o != 8'hff) rc_trim_o <= rc_trim_o + 8'h01;
          else if (!clk_sel_q && cal_cnt_q < CAL_EXPECT && rc_trim_o != 8'h00) rc_trim_o <= rc_trim_o - 8'h01;
          xtal_start_o <= 1'b0;
          cal_q <= CAL_IDLE;
        end
      endcase
    end
  end

  assign st_set[ST_EXPIRED] = expire; // [R14]
  assign st_set[ST_CAL_DONE] = (cal_q == CAL_ADJUST);
  assign st_set[ST_WINDOW_END] = win_q && unit_done && (win_cnt_q + 16'h1 >= {8'h00, duty_q});

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_expire;
    expire;
  endsequence
  a_irq_follows_expiry: assert property (@(posedge clk_i) disable iff (rst_i) // [R03]
    s_expire ##1 irq_en_q[ST_EXPIRED] |=> !interrupt_pin_n_o) else $error("irq missing after expiry");
  a_flag_set_expire: assert property (@(posedge clk_i) disable iff (rst_i) // [R14]
    expire |=> status_q[ST_EXPIRED]) else $error("expired flag not set");
  a_timer_needs_en: assert property (@(posedge clk_i) disable iff (rst_i) // [R02]
    !cfg_q[CFG_TIMER_EN] |=> !running_q) else $error("timer runs while disabled");
  a_rx_wake_select: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
    expire && duty_sel == DUTY_RX |=> action_o.wake_rx && !action_o.wake_tx) else $error("rx wake wrong");
  a_sleep_return: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
    expire |=> action_o.to_sleep == $past(exp_q[EXP_SLEEP_BIT])) else $error("post-expiry state wrong");
  a_batt_on_expiry: assert property (@(posedge clk_i) disable iff (rst_i) // [R09]
    action_o.batt_meas |-> $past(cfg_q[CFG_BATT_EN]) && $past(expire)) else $error("stray battery check");
  a_cal_power_up: assert property (@(posedge clk_i) disable iff (rst_i) // [R06]
    cal_q == CAL_IDLE && power_up_req |=> cal_q == CAL_XSTART && xtal_start_o) else $error("no calibration");
  a_cal_xtal_on: assert property (@(posedge clk_i) disable iff (rst_i) // [R08]
    cal_q == CAL_MEASURE |-> xtal_start_o) else $error("measuring without crystal");
  a_recal_gated: assert property (@(posedge clk_i) disable iff (rst_i) // [R07]
    !cfg_q[CFG_CAL_EN] |-> !recal_due) else $error("recal while disabled");
  a_window_bound: assert property (@(posedge clk_i) disable iff (rst_i) // [R13]
    win_q |-> win_cnt_q < {8'h00, duty_q}) else $error("window overran");
  a_unit_length: assert property (@(posedge clk_i) disable iff (rst_i) // [R05]
    running_q |-> unit_cnt_q < unit_len) else $error("unit counter past length");

endmodule : wkt_timer

/* File: wkt_osc_model.sv */
// oscillator model: rc and 32 kHz crystal pins plus the gated fast crystal reference
// assumes clk_i is the system clock; slow periods are shortened so a run stays brief
module wkt_osc_model #(
  parameter int RC_HALF = 8,
  parameter int XT_HALF = 12,
  parameter int REF_HALF = 4
) (
  // system
  input wire logic clk_i,
  // crystal start request from the timer
  input wire logic xtal_start_i,
  // oscillator pins
  output logic rc_osc_o,
  output logic xtal32_o,
  output logic xtal_ref_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int rc_cnt = 0;
  int xt_cnt = 0;
  int ref_cnt = 0;
  logic rc_q = 1'b0;
  logic xt_q = 1'b0;
  logic ref_q = 1'b0;
  ////////////////////////////////////////////////////////////////
  // both slow sources run free and at different rates, so the selected one shows in the period
  always @(posedge clk_i) begin
    rc_cnt <= (rc_cnt == RC_HALF - 1) ? 0 : rc_cnt + 1;
    xt_cnt <= (xt_cnt == XT_HALF - 1) ? 0 : xt_cnt + 1;
    if (rc_cnt == RC_HALF - 1) rc_q <= ~rc_q;
    if (xt_cnt == XT_HALF - 1) xt_q <= ~xt_q;
  end
  // a stopped crystal gives no edges; calibration must start it first
  always @(posedge clk_i) begin
    if (!xtal_start_i) begin
      ref_cnt <= 0;
      ref_q <= 1'b0;
    end else begin
      ref_cnt <= (ref_cnt == REF_HALF - 1) ? 0 : ref_cnt + 1;
      if (ref_cnt == REF_HALF - 1) ref_q <= ~ref_q;
    end
  end
  assign rc_osc_o = rc_q;
  assign xtal32_o = xt_q;
  assign xtal_ref_o = ref_q;
endmodule : wkt_osc_model

/* File: tb_top.sv */
// testbench: axi4-lite host sequences against the wake timer
// assumes the wkt_pkg register map and the shortened oscillator model
module tb_top;
  import wkt_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RC_PER = 16;
  localparam int XT_PER = 24;
  localparam int LIMIT = 40000;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic rc_osc, xtal32, xtal_ref;
  logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic [31:0] s_wdata = 32'h0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq_n, xtal_start, duty_win;
  logic [1:0] s_bresp, s_rresp, resp;
  logic [31:0] s_rdata, rdat;
  logic [7:0] trim;
  wkt_action_t act;
  int num_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  int t0, dt, n;
  ////////////////////////////////////////////////////////////////
  wkt_timer dut (.clk_i(clk_i), .rst_i(rst_i), .rc_osc_i(rc_osc), .xtal32_i(xtal32), .xtal_ref_i(xtal_ref),
    .s_awaddr_i(s_awaddr), .s_awvalid_i(s_awvalid), .s_awready_o(s_awready), .s_wdata_i(s_wdata),
    .s_wstrb_i(4'hf), .s_wvalid_i(s_wvalid), .s_wready_o(s_wready), .s_bresp_o(s_bresp),
    .s_bvalid_o(s_bvalid), .s_bready_i(s_bready), .s_araddr_i(s_araddr), .s_arvalid_i(s_arvalid),
    .s_arready_o(s_arready), .s_rdata_o(s_rdata), .s_rresp_o(s_rresp), .s_rvalid_o(s_rvalid),
    .s_rready_i(s_rready), .interrupt_pin_n_o(irq_n), .xtal_start_o(xtal_start), .rc_trim_o(trim),
    .action_o(act), .duty_window_o(duty_win));
  wkt_osc_model #(.RC_HALF(RC_PER / 2), .XT_HALF(XT_PER / 2), .REF_HALF(4)) osc (.clk_i(clk_i),
    .xtal_start_i(xtal_start), .rc_osc_o(rc_osc), .xtal32_o(xtal32), .xtal_ref_o(xtal_ref));
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      num_errors++;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : chk
  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end while (!s_bvalid);
    resp = s_bresp;
    s_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_arready) s_arvalid <= 1'b0;
    end while (!s_rvalid);
    rdat = s_rdata;
    resp = s_rresp;
    s_rready <= 1'b0;
  endtask : rd
  // actions are one-cycle pulses, so they are looked for at every falling edge
  task automatic wait_act(input int lim);
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (act === '0 && n < lim);
    dt = cyc - t0;
  endtask : wait_act
  task automatic run_period(input logic sel, input logic ien, input int per);
    wr(ADDR_CONTROL, {31'h0, sel});
    wr(ADDR_IRQ_ENABLE, {31'h0, ien});
    wr(ADDR_MANT_HIGH, 32'h0);
    wr(ADDR_MANT_LOW, 32'h3);
    wr(ADDR_EXP_STATE, 32'h1);
    wr(ADDR_CONFIG, 32'h1);
    t0 = cyc;
    wait_act(30 * per);
    chk(32'h1, 32'(dt >= 23 * per - 4 && dt <= 24 * per + 10));
    repeat (3) @(negedge clk_i);
    chk(32'(!ien), 32'(irq_n));
    wr(ADDR_CONFIG, 32'h0);
    if (!ien) wr(ADDR_IRQ_CLEAR, 32'h1);
    rd(ADDR_IRQ_STATUS);
    chk(32'(ien), rdat & 32'h1);
    repeat (3) @(negedge clk_i);
    chk(32'h1, 32'(irq_n));
    rd(ADDR_IRQ_STATUS);
    chk(32'h0, rdat & 32'h1);
  endtask : run_period
  ////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] ra [6];
    logic [7:0] rv [6];
    logic [1:0] du [4];
    logic bt [4];
    logic sl [4];
    logic [4:0] mask;
    ra = '{ADDR_CONFIG, ADDR_MANT_HIGH, ADDR_MANT_LOW, ADDR_EXP_STATE, ADDR_DUTY_WIN, ADDR_IRQ_STATUS};
    rv = '{RST_CONFIG, RST_MANT_HIGH, RST_MANT_LOW, RST_EXP_STATE, RST_DUTY_WIN, 8'h00};
    du = '{DUTY_OFF, DUTY_OFF, DUTY_RX, DUTY_TX};
    bt = '{1'b0, 1'b1, 1'b0, 1'b1};
    sl = '{1'b0, 1'b1, 1'b0, 1'b0};
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd(ra[i]);
      chk({24'h0, rv[i]}, rdat);
    end
    chk(32'h1, 32'(irq_n));
    chk(32'h80, {24'h0, trim});
    rv = '{8'h00, 8'ha5, 8'h5a, 8'h3f, 8'h77, 8'h00};
    for (int i = 1; i < 5; i++) wr(ra[i], {24'h0, rv[i]});
    for (int i = 1; i < 5; i++) begin
      rd(ra[i]);
      chk({24'h0, rv[i]}, rdat);
    end
    wr(8'h28, 32'h1);
    chk(32'h2, {30'h0, resp});
    rd(8'h28);
    chk(32'h2, {30'h0, resp});
    chk(32'h0, rdat);
    rd(ADDR_IRQ_CLEAR);
    chk(32'h2, {30'h0, resp});
    $display("test registers done");
    run_period(1'b0, 1'b1, RC_PER);
    run_period(1'b1, 1'b0, XT_PER);
    wr(ADDR_CONTROL, 32'h0);
    $display("test period done");
    wr(ADDR_MANT_LOW, 32'h1);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_EXP_STATE, {26'h0, sl[i], 5'h0});
      wr(ADDR_CONFIG, {28'h0, du[i], bt[i], 1'b1});
      wait_act(8 * RC_PER);
      wait_act(8 * RC_PER);
      mask = (du[i] == DUTY_OFF) ? 5'h1f : 5'h1c;
      chk({27'h0, mask & {du[i] == DUTY_RX, du[i] == DUTY_TX, bt[i], sl[i], !sl[i]}}, {27'h0, mask & act});
      chk(32'h0, 32'(xtal_start));
    end
    wr(ADDR_CONFIG, 32'h0);
    $display("test actions done");
    wr(ADDR_MANT_LOW, 32'h4);
    wr(ADDR_DUTY_WIN, 32'h2);
    wr(ADDR_CONFIG, {28'h0, DUTY_RX, 2'b01});
    wait_act(30 * RC_PER);
    wait_act(30 * RC_PER);
    chk(32'h1, 32'(act.wake_rx));
    n = 0;
    while (duty_win !== 1'b1 && n < 8) begin
      @(negedge clk_i);
      n++;
    end
    n = 0;
    while (duty_win === 1'b1 && n < 400) begin
      @(negedge clk_i);
      n++;
    end
    chk(32'h1, 32'(n >= 7 * RC_PER - 4 && n <= 9 * RC_PER + 4));
    rd(ADDR_IRQ_STATUS);
    chk(32'h4, rdat & 32'h4);
    wr(ADDR_CONFIG, 32'h0);
    wr(ADDR_IRQ_CLEAR, 32'h7);
    $display("test duty window done");
    // power-up pulse, then shutdown exit: each must run a full calibration
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_CONTROL, (i == 0) ? 32'h2 : 32'h4);
      repeat (3) @(negedge clk_i);
      chk(32'h1, 32'(xtal_start));
      n = 0;
      while (xtal_start === 1'b1 && n < 9000) begin
        @(negedge clk_i);
        n++;
      end
      chk(32'h1, 32'(n >= XTAL_START_CYC && n < 9000));
      rd(ADDR_IRQ_STATUS);
      chk(32'h2, rdat & 32'h2);
    end
    chk(32'h1, 32'(trim !== 8'h80));
    $display("test calibration done");
    give_verdict();
  end
endmodule : tb_top
